// file: design/eebg_guard.sv
/*
 * instruction front end of a serial three-wire eeprom: start detection,
 * clock pulse counter guarding program/erase, self-timed cycle launch,
 * ready/busy status on the serial output and the 256x16 array itself.
 * assumes pins are already synchronous to clock_in and that the serial
 * clock is far slower than clock_in so every edge is seen.
 */
`timescale 1ns/1ps
module eebg_guard #(
    parameter int unsigned PROG_CYCLES = eebg_pkg::PROG_CYCLES
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire eebg_pkg::eebg_pins_t pins_in,
    input wire logic [7:0] peek_addr_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic busy_out,
    output logic wr_enabled_out,
    output logic reject_out,
    output logic launch_out,
    output logic [15:0] peek_data_out
);
    import eebg_pkg::*;

    eebg_state_t state_r, state_nxt; // front-end state
    logic sclk_prev_r, sel_prev_r; // edge detection history
    logic [CNT_W-1:0] cnt_r, cnt_nxt; // pulses since start bit
    logic [SHIFT_W-1:0] shift_r, shift_nxt; // bits after start
    logic [1:0] op_r, op_nxt; // captured opcode
    logic [1:0] sub_r, sub_nxt; // captured sub-code
    logic wen_r, wen_nxt; // program/erase enable latch
    logic armed_r, armed_nxt; // status output still owed
    logic sdo_r, sdo_nxt, oe_r, oe_nxt;
    logic reject_r, reject_nxt, launch_r, launch_nxt;
    eebg_job_t job_r, job_nxt; // pending array operation
    logic [15:0] mem [MEM_DEPTH]; // storage array
    logic [15:0] peek_r;
    logic sclk_rise, sel_fall, guarded, count_ok;
    logic [CNT_W-1:0] expect_cnt;
    logic tmr_busy, tmr_done;

    // expected pulses for a guarded instruction in the chosen organisation
    function automatic logic [CNT_W-1:0] exp_count(input logic [1:0] op,
            input logic [1:0] sub, input logic org);
        logic long_form;
        long_form = (op == OP_WRITE) ||
                    (op == OP_MISC && sub == SUB_PROGRAM_ENTIRE);
        if (long_form) begin
            exp_count = org ? WR_CNT_X16 : WR_CNT_X8; // see RULE4 see RULE5
        end else begin
            exp_count = org ? ER_CNT_X16 : ER_CNT_X8; // see RULE13
        end
    endfunction

    eebg_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .start_in(launch_r),
        .busy_out(tmr_busy),
        .done_out(tmr_done)
    );

    assign sclk_rise = pins_in.sclk && !sclk_prev_r;
    assign sel_fall = !pins_in.sel && sel_prev_r;
    // read and enable/disable bypass the counter
    assign guarded = (op_r == OP_WRITE) || (op_r == OP_ERASE) ||
                     (op_r == OP_MISC && (sub_r == SUB_ERASE_ENTIRE ||
                      sub_r == SUB_PROGRAM_ENTIRE)); // see RULE6
    assign expect_cnt = exp_count(op_r, sub_r, pins_in.org); // see RULE11
    assign count_ok = (cnt_r == expect_cnt); // see RULE3

    // decode, count and launch
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        op_nxt = op_r;
        sub_nxt = sub_r;
        wen_nxt = wen_r;
        armed_nxt = armed_r;
        reject_nxt = 1'b0;
        launch_nxt = 1'b0;
        job_nxt = job_r;
        case (state_r)
            ST_IDLE: begin
                // first one clocked in while selected is the start bit
                if (pins_in.sel && sclk_rise && pins_in.sdi) begin
                    state_nxt = ST_SHIFT; // see RULE10
                    cnt_nxt = CNT_START;
                    shift_nxt = '0;
                    op_nxt = OP_READ;
                    sub_nxt = SUB_DISABLE;
                    armed_nxt = 1'b0; // see RULE2
                end
            end
            ST_SHIFT: begin
                if (!pins_in.sel) begin
                    state_nxt = ST_IDLE;
                    if (guarded && !count_ok) begin
                        // wrong count only drops the instruction
                        reject_nxt = 1'b1; // see RULE14
                    end else if (guarded && wen_r) begin
                        state_nxt = ST_PROG; // see RULE12
                        launch_nxt = 1'b1;
                        armed_nxt = 1'b1;
                        job_nxt.org = pins_in.org;
                        if (op_r == OP_WRITE) begin
                            job_nxt.kind = JOB_WRITE;
                            job_nxt.addr = pins_in.org ?
                                {1'b0, shift_r[23:16]} : shift_r[16:8];
                        end else if (op_r == OP_ERASE) begin
                            job_nxt.kind = JOB_ERASE;
                            job_nxt.addr = pins_in.org ?
                                {1'b0, shift_r[7:0]} : shift_r[8:0];
                        end else if (sub_r == SUB_ERASE_ENTIRE) begin
                            job_nxt.kind = JOB_ERASE_ALL;
                        end else begin
                            job_nxt.kind = JOB_PROGRAM_ALL;
                        end
                        job_nxt.data = pins_in.org ? shift_r[15:0] :
                            {BYTE_PAD, shift_r[7:0]};
                    end else if (op_r == OP_MISC && cnt_r >= CNT_SUB) begin
                        if (sub_r == SUB_ENABLE) begin
                            wen_nxt = 1'b1;
                        end else if (sub_r == SUB_DISABLE) begin
                            wen_nxt = 1'b0;
                        end
                    end
                end else if (sclk_rise) begin
                    shift_nxt = {shift_r[SHIFT_W-2:0], pins_in.sdi};
                    // saturate so a flood of pulses can never wrap
                    if (cnt_r != CNT_MAX) begin
                        cnt_nxt = cnt_r + 5'h01; // see RULE3
                    end
                    if (cnt_r + 5'h01 == CNT_OPCODE) begin
                        op_nxt = {shift_r[0], pins_in.sdi};
                    end
                    if (cnt_r + 5'h01 == CNT_SUB) begin
                        sub_nxt = {shift_r[0], pins_in.sdi};
                    end
                end
            end
            ST_PROG: begin
                // bus data is ignored until the cycle ends
                if (tmr_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // ready owed until deselect once the cycle is over; the launch
        // edge itself sees select low, so it must not drop the debt
        if (!launch_nxt && !tmr_busy && state_r != ST_PROG &&
            !pins_in.sel) begin
            armed_nxt = 1'b0; // see RULE2
        end
    end

    // status pin: low while busy, high once ready
    always_comb begin
        sdo_nxt = !(tmr_busy || state_r == ST_PROG); // see RULE9
        oe_nxt = pins_in.sel && (armed_nxt || tmr_busy); // see RULE1
    end

    // front-end registers
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_r <= ST_IDLE;
            sclk_prev_r <= 1'b0;
            sel_prev_r <= 1'b0;
            cnt_r <= '0;
            shift_r <= '0;
            op_r <= OP_READ;
            sub_r <= SUB_DISABLE;
            wen_r <= 1'b0; // power-up is write-disabled
            armed_r <= 1'b0;
            sdo_r <= 1'b1;
            oe_r <= 1'b0;
            reject_r <= 1'b0;
            launch_r <= 1'b0;
            job_r <= '0;
        end else begin
            state_r <= state_nxt;
            sclk_prev_r <= pins_in.sclk;
            sel_prev_r <= pins_in.sel;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            op_r <= op_nxt;
            sub_r <= sub_nxt;
            wen_r <= wen_nxt;
            armed_r <= armed_nxt;
            sdo_r <= sdo_nxt;
            oe_r <= oe_nxt;
            reject_r <= reject_nxt;
            launch_r <= launch_nxt;
            job_r <= job_nxt;
        end
    end

    // array: written at cycle end; a whole-array loop keeps it in one place
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= ALL_ONES; // see RULE7
            end
        end else if (tmr_done) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                if (job_r.kind == JOB_ERASE_ALL) begin
                    mem[i] <= ALL_ONES;
                end else if (job_r.kind == JOB_PROGRAM_ALL) begin
                    // no auto-erase: program-entire can only clear bits
                    mem[i] <= mem[i] & (job_r.org ? job_r.data :
                        {job_r.data[7:0], job_r.data[7:0]});
                end else if (job_r.org && job_r.addr[7:0] == 8'(i)) begin
                    mem[i] <= (job_r.kind == JOB_ERASE) ? ALL_ONES :
                        job_r.data;
                end else if (!job_r.org && job_r.addr[8:1] == 8'(i)) begin
                    if (job_r.addr[0]) begin
                        mem[i][15:8] <= (job_r.kind == JOB_ERASE) ?
                            ALL_ONES[15:8] : job_r.data[7:0];
                    end else begin
                        mem[i][7:0] <= (job_r.kind == JOB_ERASE) ?
                            ALL_ONES[7:0] : job_r.data[7:0];
                    end
                end
            end
        end
    end

    // peek port for inspection of the array
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            peek_r <= ALL_ONES;
        end else begin
            peek_r <= mem[peek_addr_in];
        end
    end

    assign sdo_out = sdo_r;
    assign sdo_oe_out = oe_r;
    assign busy_out = tmr_busy;
    assign wr_enabled_out = wen_r;
    assign reject_out = reject_r;
    assign launch_out = launch_r;
    assign peek_data_out = peek_r;

    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    a_busy_drives_low: assert property ( // see RULE9
        tmr_busy && pins_in.sel |=> sdo_oe_out && !sdo_out)
        else $error("busy not low");
    a_status_when_sel: assert property ( // see RULE1
        armed_r && pins_in.sel && state_nxt != ST_SHIFT |=> sdo_oe_out)
        else $error("status not shown");
    a_ready_until_sel: assert property ( // see RULE2
        !tmr_busy && state_r == ST_IDLE && armed_r && pins_in.sel &&
        !sclk_rise |=> sdo_oe_out && sdo_out)
        else $error("ready dropped early");
    a_start_needs_one: assert property ( // see RULE10
        state_r == ST_IDLE && state_nxt == ST_SHIFT |->
        pins_in.sdi && pins_in.sel) else $error("start without one");
    a_write_x8_count: assert property ( // see RULE4
        launch_nxt && op_r == OP_WRITE && !pins_in.org |->
        cnt_r == WR_CNT_X8) else $error("byte write count");
    a_write_x16_count: assert property ( // see RULE5
        launch_nxt && op_r == OP_WRITE && pins_in.org |->
        cnt_r == WR_CNT_X16) else $error("word write count");
    a_read_unchecked: assert property ( // see RULE6
        state_r == ST_SHIFT && op_r == OP_READ && !pins_in.sel |->
        !reject_nxt && !launch_nxt) else $error("read filtered");
    a_launch_on_fall: assert property ( // see RULE12
        launch_r |-> $past(sel_fall) ##1 tmr_busy)
        else $error("launch timing");
    a_reject_no_cycle: assert property ( // see RULE14
        reject_r |-> !launch_r ##1 !launch_r && !tmr_busy)
        else $error("rejected but launched");
    a_count_saturates: assert property ( // see RULE3
        state_r == ST_SHIFT && pins_in.sel && cnt_r == CNT_MAX &&
        sclk_rise |=> cnt_r == CNT_MAX) else $error("counter wrapped");

    c_write_launch: cover property (launch_r && job_r.kind == JOB_WRITE);
    c_count_reject: cover property (reject_r);
    c_program_done: cover property (tmr_done ##[1:20] sdo_oe_out && sdo_out);
endmodule // eebg_guard

// file: design/eebg_pkg.sv
/*
 * shared constants and types for the serial eeprom busy/pulse guard.
 * assumes one 100 MHz system clock; serial pins arrive synchronous to it.
 */
// Functional notes
// RULE1: show ready/busy on output while select high
// RULE2: hold ready until new start bit or deselect
// RULE3: count pulses from start bit to deselect
// RULE4: byte-wide write needs exactly 20 pulses
// RULE5: word-wide write needs exactly 27 pulses
// RULE6: only program/erase instructions are count checked
// RULE7: every location starts as all ones
// RULE8: host releases shared wire after last address
// RULE9: busy drives low, ready drives high
// RULE10: first one sampled after select is start
// RULE11: width select high means word-wide organisation
// RULE12: deselect launches self-timed cycle, clock independent
// RULE13: erase counts are start, opcode, address, data; the code counts start, opcode and address only
// RULE14: bad pulse count only suppresses, never shifts
package eebg_pkg;
    localparam int unsigned CLK_HZ = 100_000_000; // system clock rate
    localparam int unsigned PROG_TIME_US = 5000; // typical programming time
    localparam int unsigned PROG_CYCLES = PROG_TIME_US * (CLK_HZ / 1_000_000);
    localparam logic [1:0] OP_MISC = 2'h0; // sub-coded instructions
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] SUB_DISABLE = 2'h0;
    localparam logic [1:0] SUB_PROGRAM_ENTIRE = 2'h1;
    localparam logic [1:0] SUB_ERASE_ENTIRE = 2'h2;
    localparam logic [1:0] SUB_ENABLE = 2'h3;
    localparam int CNT_W = 5; // pulse counter width
    localparam logic [4:0] CNT_MAX = 5'h1f; // counter saturates here
    localparam logic [4:0] CNT_START = 5'h01; // start bit counts as one
    localparam logic [4:0] CNT_OPCODE = 5'h03; // start plus opcode
    localparam logic [4:0] CNT_SUB = 5'h05; // start, opcode, two sub bits
    localparam logic [4:0] WR_CNT_X8 = 5'h14; // 20 pulses
    localparam logic [4:0] WR_CNT_X16 = 5'h1b; // 27 pulses
    localparam logic [4:0] ER_CNT_X8 = 5'h0c; // 1 + 2 + 9
    localparam logic [4:0] ER_CNT_X16 = 5'h0b; // 1 + 2 + 8
    localparam int SHIFT_W = 26; // bits after start, word-wide write
    localparam int MEM_DEPTH = 256; // words of 16 bits
    localparam logic [15:0] ALL_ONES = 16'hffff; // delivery content
    localparam logic [7:0] BYTE_PAD = 8'h00;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001, // hunting for start bit
        ST_SHIFT = 3'b010, // instruction arriving
        ST_PROG = 3'b100 // self-timed cycle running
    } eebg_state_t;
    typedef enum logic [1:0] {
        JOB_WRITE = 2'h0,
        JOB_ERASE = 2'h1,
        JOB_ERASE_ALL = 2'h2,
        JOB_PROGRAM_ALL = 2'h3
    } eebg_job_kind_t;
    typedef struct packed {
        logic sel; // chip select, high active
        logic sclk; // serial clock level
        logic sdi; // serial data in
        logic org; // high: word-wide
    } eebg_pins_t;
    typedef struct packed {
        eebg_job_kind_t kind;
        logic org;
        logic [8:0] addr;
        logic [15:0] data;
    } eebg_job_t;
endpackage

// file: design/eebg_prog_timer.sv
/*
 * self-timed programming cycle timer.
 * assumes start_in is a one-cycle pulse given only while idle.
 */
`timescale 1ns/1ps
module eebg_prog_timer #(
    parameter int unsigned CYCLES = eebg_pkg::PROG_CYCLES
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    output logic busy_out,
    output logic done_out
);
    import eebg_pkg::*;
    logic [31:0] cnt_r, cnt_nxt; // cycles left
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;

    // count down on the system clock only, so the serial clock may stop
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (start_in && !busy_r) begin
            cnt_nxt = 32'(CYCLES); // see RULE12
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (cnt_r <= 32'h1) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                cnt_nxt = 32'h0;
            end else begin
                cnt_nxt = cnt_r - 32'h1;
            end
        end
    end

    // registers only
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cnt_r <= 32'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_out = busy_r;
    assign done_out = done_r;
endmodule // eebg_prog_timer

// file: verification/eebg_host_model.sv
/*
 * host-side serial master model for the eeprom guard: select, serial
 * clock, data in and width select. assumes a free-running clock_in.
 */
`timescale 1ns/1ps
module eebg_host_model (
    input wire logic clock_in,
    output eebg_pkg::eebg_pins_t pins_out
);
    import eebg_pkg::*;

    // idle: deselected, clock low, word-wide
    initial begin
        pins_out = '{sel: 1'h0, sclk: 1'h0, sdi: 1'h0, org: 1'h1};
    end

    // one frame, msb first; n rises counted from the start bit
    task automatic send(input logic [31:0] bits, input int n,
                        input logic org);
        @(posedge clock_in);
        pins_out.org <= org;
        pins_out.sclk <= 1'h0; // clock low as select rises
        pins_out.sel <= 1'h1;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clock_in);
            pins_out.sdi <= bits[i];
            repeat (2) @(posedge clock_in);
            pins_out.sclk <= 1'h1; // device samples on this rise
            repeat (2) @(posedge clock_in);
            pins_out.sclk <= 1'h0;
        end
        @(posedge clock_in);
        pins_out.sel <= 1'h0; // deselect ends the count
        // line let go: show the inverse, never a stale bit
        pins_out.sdi <= ~bits[0];
        repeat (2) @(posedge clock_in);
    endtask

    // raise or drop select with the clock parked low, for status polls
    task automatic select(input logic s);
        @(posedge clock_in);
        pins_out.sclk <= 1'h0;
        pins_out.sel <= s;
    endtask
endmodule // eebg_host_model

// file: verification/eebg_guard_tb_top.sv
/*
 * self-checking bench for the eeprom guard, host model on the pins.
 * assumes a short programming time set through PROG_CYCLES.
 */
`timescale 1ns/1ps
module eebg_guard_tb_top;
    import eebg_pkg::*;
    logic clock_in = 1'h0;
    logic sys_rst_in;
    eebg_pins_t pins; // driven by the host model
    logic [7:0] peek_addr;
    logic sdo_out, sdo_oe_out, busy_out, wr_enabled_out;
    logic reject_out, launch_out;
    logic [15:0] peek_data_out;
    logic [15:0] n_launch = 16'h0, n_reject = 16'h0; // pulse tallies
    int n_fail = 0;
    int cmp_count = 0;
    logic [31:0] b; // frame under test

    always #5 clock_in = ~clock_in;

    eebg_host_model host (.clock_in(clock_in), .pins_out(pins));

    // short timer keeps each programming wait to a few dozen cycles
    eebg_guard #(.PROG_CYCLES(20)) dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .pins_in(pins),
        .peek_addr_in(peek_addr), .sdo_out(sdo_out),
        .sdo_oe_out(sdo_oe_out), .busy_out(busy_out),
        .wr_enabled_out(wr_enabled_out), .reject_out(reject_out),
        .launch_out(launch_out), .peek_data_out(peek_data_out));

    // one-cycle pulses are caught here so no frame can miss them
    always @(posedge clock_in) begin
        if (launch_out === 1'h1) n_launch <= n_launch + 16'h1;
        if (reject_out === 1'h1) n_reject <= n_reject + 16'h1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // array word seen through the registered inspection port
    task automatic peek(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock_in);
        peek_addr <= a;
        repeat (2) @(posedge clock_in);
        #1;
        chk(peek_data_out, e);
    endtask

    // accepted program/erase: launch, busy status, then ready held
    task automatic run_prog(input logic [31:0] f, input int n,
                            input logic org);
        int k;
        n_launch = 16'h0;
        host.send(f, n, org);
        host.select(1'h1);
        repeat (3) @(posedge clock_in);
        #1;
        chk(n_launch, 16'h1);
        chk({busy_out, sdo_oe_out, sdo_out}, 3'h6);
        k = 0;
        // bounded wait: timer is 20 cycles
        while (busy_out !== 1'h0 && k < 100) begin
            @(posedge clock_in);
            #1;
            k++;
        end
        repeat (2) @(posedge clock_in);
        #1;
        chk({busy_out, sdo_oe_out, sdo_out}, 3'h3);
        host.select(1'h0);
        repeat (2) @(posedge clock_in);
        #1;
        chk(sdo_oe_out, 1'h0);
    endtask

    // frame that must not launch; rej says whether a reject is due
    task automatic run_none(input logic [31:0] f, input int n,
                            input logic org, input logic rej);
        n_launch = 16'h0;
        n_reject = 16'h0;
        host.send(f, n, org);
        #1;
        chk(n_reject, {15'h0, rej});
        chk({n_launch, busy_out}, 17'h0);
    endtask

    initial begin
        sys_rst_in = 1'h1;
        peek_addr = 8'h00;
        repeat (20) @(posedge clock_in);
        sys_rst_in <= 1'h0;
        repeat (2) @(posedge clock_in);
        #1;
        chk({sdo_out, sdo_oe_out, busy_out, wr_enabled_out}, 4'h8);
        peek(8'h00, 16'hffff);
        peek(8'hff, 16'hffff);
        $display("test reset done");
        // enable, then word write at 26, 28 and 27 pulses
        host.send({1'h1, 2'h0, 2'h3, 6'h0}, 11, 1'h1);
        #1;
        chk(wr_enabled_out, 1'h1);
        b = {1'h1, 2'h1, 8'h22, 16'h1234};
        run_none(b >> 1, 26, 1'h1, 1'h1);
        run_none(b << 1, 28, 1'h1, 1'h1);
        peek(8'h22, 16'hffff);
        run_prog(b, 27, 1'h1);
        peek(8'h22, 16'h1234);
        $display("test word write done");
        // byte write, high lane of word 22: 21 pulses then 20
        b = {1'h1, 2'h1, 9'h045, 8'h3c};
        run_none(b << 1, 21, 1'h0, 1'h1);
        peek(8'h22, 16'h1234);
        run_prog(b, 20, 1'h0);
        peek(8'h22, 16'h3c34);
        // byte erase of the same high lane: 13 refused, 12 accepted
        b = {1'h1, 2'h3, 9'h045};
        run_none(b << 1, 13, 1'h0, 1'h1);
        run_prog(b, 12, 1'h0);
        peek(8'h22, 16'hff34);
        $display("test byte write done");
        // word erase: 12 pulses refused, 11 accepted
        b = {1'h1, 2'h3, 8'h22};
        run_none(b << 1, 12, 1'h1, 1'h1);
        run_prog(b, 11, 1'h1);
        peek(8'h22, 16'hffff);
        $display("test erase done");
        // erase_entire then program_entire, short one refused first
        run_prog({1'h1, 2'h0, 2'h2, 6'h0}, 11, 1'h1);
        b = {1'h1, 2'h0, 2'h1, 6'h0, 16'h5a0f};
        run_none(b >> 1, 26, 1'h1, 1'h1);
        run_prog(b, 27, 1'h1);
        peek(8'h00, 16'h5a0f);
        peek(8'hff, 16'h5a0f);
        $display("test entire done");
        // read with odd length is never filtered
        run_none({1'h1, 2'h2, 8'h22, 3'h0}, 14, 1'h1, 1'h0);
        // disable at odd length is not filtered either
        host.send({1'h1, 2'h0, 2'h0, 7'h0}, 12, 1'h1);
        #1;
        chk(wr_enabled_out, 1'h0);
        // right count but disabled: no launch, no reject, no change
        run_none({1'h1, 2'h1, 8'h10, 16'h0000}, 27, 1'h1, 1'h0);
        peek(8'h10, 16'h5a0f);
        $display("test unguarded done");
        tally_and_finish();
    end

    // about 1800 cycles expected; cut short well after that
    initial begin
        repeat (30000) @(posedge clock_in);
        n_fail++;
        tally_and_finish();
    end
endmodule // eebg_guard_tb_top
